// *** hw/cr_regs.svh ***
// Register map, field positions, reset values and timing constants.
// Assumes inclusion by the console control package and top module.
`ifndef CR_REGS_SVH
`define CR_REGS_SVH

// Register byte offsets
`define CR_OFF_CTRL     12'h000
`define CR_OFF_REMOTE   12'h004
`define CR_OFF_BTN      12'h008
`define CR_OFF_KNOB     12'h00C
`define CR_OFF_STATUS   12'h010

// Control register fields
`define CR_CTRL_AUX_LSB     0
`define CR_CTRL_MICSRC_BIT  2
`define CR_CTRL_MICOUT_BIT  3
`define CR_CTRL_FLOOR_LSB   4
`define CR_CTRL_STMODE_LSB  6
`define CR_CTRL_STROUTE_LSB 8
`define CR_CTRL_W           10
`define CR_CTRL_RST         10'h300

// Remote map: four bits per contact, button modes: two bits per function
`define CR_REM_FW       4
`define CR_REM_RST      16'h0000
`define CR_BTN_FW       2
`define CR_BTN_RST      14'h0000
`define CR_KNOB_RST     8'hFF
`define CR_TALLY_INPUT  1

// Status register fields
`define CR_ST_MAIN_BIT  0
`define CR_ST_TB_LSB    1
`define CR_ST_MUTE_LSB  7
`define CR_ST_REM_LSB   15
`define CR_ST_TALLY_BIT 19

// Level floors in dB of attenuation
`define CR_FLOOR_30_DB  6'h1E
`define CR_FLOOR_40_DB  6'h28

// Timing
`define CR_CLK_HZ       25000000
`define CR_MS_CYC       (`CR_CLK_HZ / 1000)
`define CR_FS_HZ        48000
`define CR_FS_CYC       (`CR_CLK_HZ / `CR_FS_HZ)
`define CR_DEB_MS       10
`define CR_HOLD_MS      500
`define CR_FLASH_MS     100
`define CR_FLASHES      5
`define CR_TALLY_HZ     20000
`define CR_MARK_HZ      18000
`define CR_STEP(hz)     ((hz) * 65536 / `CR_FS_HZ)

`endif

// *** hw/cr_pkg.sv ***
// Types shared by the console control logic.
// Assumes the register header is on the include path.
`include "cr_regs.svh"
package cr_pkg;
    typedef enum logic [1:0] {CR_AUX_OFF, CR_AUX_HOT_MIC, CR_AUX_TALLY, CR_AUX_MARK} cr_aux_e;
    typedef enum logic [1:0] {CR_ST_OFF, CR_ST_MAIN, CR_ST_TB, CR_ST_BOTH} cr_st_e;
    typedef enum logic [1:0] {CR_FL_30, CR_FL_40, CR_FL_MUTE, CR_FL_RSV} cr_floor_e;
    typedef enum logic [1:0] {CR_BM_MOMENT, CR_BM_LATCH, CR_BM_HYBRID, CR_BM_RSV} cr_btn_e;
    typedef logic [3:0] cr_rfn_t;
    localparam cr_rfn_t CR_RFN_OFF   = 4'h0;
    localparam cr_rfn_t CR_RFN_MAIN  = 4'h1;
    localparam cr_rfn_t CR_RFN_TB6   = 4'h7;
    localparam cr_rfn_t CR_RFN_TALLY = 4'h8;
endpackage

// *** hw/cr_tone.sv ***
// Sine tone source at -20 dBFS, one sample per sample strobe.
// Assumes a sample strobe at the rate the phase step was derived for.
module cr_tone
    import cr_pkg::*;
#(
    parameter logic [15:0] STEP = 16'h6AAB
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Sample strobe and tone
    input  wire logic               en,
    output logic signed [15:0]      tone
);
    // Quarter wave, peak one tenth of 16-bit full scale
    localparam logic [15:0] QW [0:8] = '{16'h0000, 16'h027F, 16'h04E6, 16'h071C,
        16'h090D, 16'h0AA4, 16'h0BD3, 16'h0C8E, 16'h0CCD};

    logic [15:0] phase_q;
    wire  [2:0]  qi   = phase_q[13:11];
    wire  [3:0]  qix  = phase_q[11] | phase_q[12] | phase_q[13] ? 4'h8 - {1'b0, qi} : 4'h8;
    wire  [15:0] mag  = phase_q[14] ? QW[qix] : QW[{1'b0, qi}];

    // Phase accumulator and registered sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 16'h0000;
            tone    <= 16'sh0000;
        end else if (en) begin
            phase_q <= phase_q + STEP;
            tone    <= phase_q[15] ? -$signed(mag) : $signed(mag);
        end
    end
endmodule

// *** hw/cr_console.sv ***
// Announcer console control: aux channel, mic pass-through, levels,
// sidetone, remote contacts and knob mute. APB slave, zero wait states.
// Assumes synchronous panel inputs and audio samples valid at all times.
//
// The register addresses and register access over APB were decided locally.
`include "cr_regs.svh"
// Summary of operation
// - Aux transmit selects off, hot mic, tally tone or mic plus marker tone.
// - Hot mic puts preamp audio on aux continuously; buttons cannot remove it.
// - Hot mic takes preamp audio from the analog mic input always.
// - Tally mode sends 20 kHz at -20 dBFS while main is active.
// - Marker mode sends selected mic plus 18 kHz tone while main active.
// - Switched mic output passes analog mic only while main is active.
// - Always-on mic output passes analog mic at all times.
// - Eight encoder levels stop at -30 or -40 dB, or fully mute.
// - Main sidetone mode feeds headphones while mic is on main.
// - Talkback sidetone mode enables sidetone while any talkback is active.
// - Combined sidetone mode enables on main or any talkback active.
// - Sidetone goes left, right or both, same for analog and network.
// - Four remote contacts, each mapped to a button function or nothing.
// - Remote mapped to main acts as a main press; off does nothing.
// - Remote mapped to talkback follows that button's configured mode.
// - Remote 2 adds a tally option; remotes 3 and 4 match remote 1.
// - Tally option drives remote 2 pin high while main is active.
// - Knob tap with silence on toggles its channel mute; knob shows purple while muted.
// - Knob tap with silence off keeps mute and flashes purple five times.
// - Main encoder 2 has its own independent knob silence setting.
// - Encoder lights are blue in normal operation and purple when muted.
module cr_console
    import cr_pkg::*;
#(
    parameter int AW       = 16,
    parameter int MS_CYC   = `CR_MS_CYC,
    parameter int FS_CYC   = `CR_FS_CYC,
    parameter int DEB_MS   = `CR_DEB_MS,
    parameter int HOLD_MS  = `CR_HOLD_MS,
    parameter int FLASH_MS = `CR_FLASH_MS
) (
    // APB
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Front panel
    input  wire logic               main_btn,
    input  wire logic [5:0]         tb_btn,
    input  wire logic [7:0]         knob_press,
    input  wire logic [7:0]         enc_cw,
    input  wire logic [7:0]         enc_ccw,
    // Remote contacts, remote 2 doubles as tally output
    input  wire logic [3:0]         remote_i,
    output logic      [3:0]         remote_o,
    output logic      [3:0]         remote_oe,
    // Audio
    input  wire logic signed [AW-1:0] mic_analog,
    input  wire logic signed [AW-1:0] mic_net,
    output logic signed [AW-1:0]    aux_tx,
    output logic signed [AW-1:0]    mic_out,
    output logic                    preamp_analog,
    output logic                    main_on,
    output logic      [5:0]         tb_on,
    output logic                    st_left,
    output logic                    st_right,
    // Encoder levels and lights
    output logic      [47:0]        enc_attn,
    output logic      [7:0]         enc_mute,
    output logic      [7:0]         knob_blue,
    output logic      [7:0]         knob_purple
);
    localparam int MSW = $clog2(MS_CYC + 1);
    localparam int FSW = $clog2(FS_CYC + 1);
    localparam int HW  = $clog2(HOLD_MS + 1);
    localparam int DW  = $clog2(DEB_MS + 1);
    localparam int FW  = $clog2(FLASH_MS + 1);

    // Parameter sanity
    if (AW < 16 || MS_CYC < 1 || FS_CYC < 1 || DEB_MS < 1 || HOLD_MS < 1 || FLASH_MS < 1) begin : g_bad
        $error("cr_console: unsupported parameter value");
    end

    // Millisecond and sample-rate enables
    logic [MSW-1:0] ms_cnt_q;
    logic [FSW-1:0] fs_cnt_q;
    logic           ms_tick_q;
    logic           fs_tick_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_q  <= '0;
            fs_cnt_q  <= '0;
            ms_tick_q <= 1'b0;
            fs_tick_q <= 1'b0;
        end else begin
            ms_tick_q <= ms_cnt_q == MSW'(MS_CYC - 1);
            fs_tick_q <= fs_cnt_q == FSW'(FS_CYC - 1);
            ms_cnt_q  <= ms_cnt_q == MSW'(MS_CYC - 1) ? '0 : ms_cnt_q + 1'b1;
            fs_cnt_q  <= fs_cnt_q == FSW'(FS_CYC - 1) ? '0 : fs_cnt_q + 1'b1;
        end
    end

    // Configuration registers
    logic [`CR_CTRL_W-1:0] ctrl_q;
    logic [15:0]           remote_q;
    logic [13:0]           btn_q;
    logic [7:0]            knob_en_q;

    // APB decode
    wire setup   = psel & ~penable;
    wire wr_en   = psel & penable & pwrite;
    wire hit_ctl = paddr == `CR_OFF_CTRL;
    wire hit_rem = paddr == `CR_OFF_REMOTE;
    wire hit_btn = paddr == `CR_OFF_BTN;
    wire hit_knb = paddr == `CR_OFF_KNOB;
    wire hit_sts = paddr == `CR_OFF_STATUS;
    wire hit_any = hit_ctl | hit_rem | hit_btn | hit_knb | hit_sts;

    // Field views
    wire cr_aux_e   aux_mode = cr_aux_e'(ctrl_q[`CR_CTRL_AUX_LSB +: 2]);
    wire            mic_net_sel = ctrl_q[`CR_CTRL_MICSRC_BIT];
    wire            mic_always  = ctrl_q[`CR_CTRL_MICOUT_BIT];
    wire cr_floor_e floor_mode  = cr_floor_e'(ctrl_q[`CR_CTRL_FLOOR_LSB +: 2]);
    wire cr_st_e    st_mode     = cr_st_e'(ctrl_q[`CR_CTRL_STMODE_LSB +: 2]);
    wire [1:0]      st_route    = ctrl_q[`CR_CTRL_STROUTE_LSB +: 2];
    wire [5:0]      floor_db    = floor_mode == CR_FL_30 ? `CR_FLOOR_30_DB : `CR_FLOOR_40_DB;
    wire            tally_sel   = remote_q[`CR_TALLY_INPUT*`CR_REM_FW +: `CR_REM_FW] == CR_RFN_TALLY;

    // Remote map write legalising: tally code only on remote 2
    wire [15:0] remote_wr;
    for (genvar i = 0; i < 4; i++) begin : g_rwr
        wire cr_rfn_t v = pwdata[i*`CR_REM_FW +: `CR_REM_FW];
        assign remote_wr[i*`CR_REM_FW +: `CR_REM_FW] = (v <= CR_RFN_TB6) ? v :
            (v == CR_RFN_TALLY && i == `CR_TALLY_INPUT) ? v : CR_RFN_OFF;
    end

    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= `CR_CTRL_RST;
            remote_q  <= `CR_REM_RST;
            btn_q     <= `CR_BTN_RST;
            knob_en_q <= `CR_KNOB_RST;
        end else if (wr_en) begin
            if (hit_ctl) ctrl_q <= pwdata[`CR_CTRL_W-1:0];
            if (hit_rem) remote_q <= remote_wr;
            if (hit_btn) btn_q <= pwdata[13:0];
            if (hit_knb) knob_en_q <= pwdata[7:0];
        end
    end

    // Block state
    logic [6:0] act_q;
    logic [3:0] deb_q;
    logic [7:0] kmute_q;
    logic       tally_q;

    // Read mux, registered during the setup cycle
    wire [31:0] status = {12'h000, tally_q, deb_q, kmute_q, act_q};
    wire [31:0] rd_mux = hit_ctl ? {{(32-`CR_CTRL_W){1'b0}}, ctrl_q} :
                         hit_rem ? {16'h0000, remote_q} :
                         hit_btn ? {18'h00000, btn_q} :
                         hit_knb ? {24'h000000, knob_en_q} :
                         hit_sts ? status : 32'h00000000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata  <= pwrite ? 32'h00000000 : rd_mux;
                pslverr <= ~hit_any | (pwrite & hit_sts);
            end
        end
    end

    // Remote contacts: two-flop sync, debounce, closure is low
    for (genvar i = 0; i < 4; i++) begin : g_rem
        logic          s1_q;
        logic          s2_q;
        logic [DW-1:0] dcnt_q;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1_q     <= 1'b1;
                s2_q     <= 1'b1;
                dcnt_q   <= '0;
                deb_q[i] <= 1'b0;
            end else begin
                s1_q <= remote_i[i];
                s2_q <= s1_q;
                if (~s2_q == deb_q[i]) dcnt_q <= '0;
                else if (ms_tick_q) dcnt_q <= dcnt_q + 1'b1;
                if (~s2_q != deb_q[i] && ms_tick_q && dcnt_q == DW'(DEB_MS - 1))
                    deb_q[i] <= ~s2_q;
            end
        end
    end

    // Remote to function matching: index 0 main, 1..6 talkback
    wire [27:0] rhit;
    wire [6:0]  press;
    for (genvar f = 0; f < 7; f++) begin : g_map
        for (genvar i = 0; i < 4; i++) begin : g_in
            assign rhit[f*4+i] = deb_q[i] & (remote_q[i*`CR_REM_FW +: `CR_REM_FW] == cr_rfn_t'(f + 1));
        end
        assign press[f] = (f == 0 ? main_btn : tb_btn[(f == 0) ? 0 : f-1]) | (|rhit[f*4 +: 4]);
    end

    // Button functions: momentary, latching or hybrid
    for (genvar f = 0; f < 7; f++) begin : g_btn
        logic          prs_q;
        logic [HW-1:0] held_q;
        wire cr_btn_e  md   = cr_btn_e'(btn_q[f*`CR_BTN_FW +: `CR_BTN_FW]);
        wire           rise = press[f] & ~prs_q;
        wire           fall = ~press[f] & prs_q;
        wire           lng  = held_q == HW'(HOLD_MS);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                prs_q    <= 1'b0;
                held_q   <= '0;
                act_q[f] <= 1'b0;
            end else begin
                prs_q <= press[f];
                if (rise) held_q <= '0;
                else if (press[f] && ms_tick_q && !lng) held_q <= held_q + 1'b1;
                if (rise) act_q[f] <= (md == CR_BM_MOMENT) ? 1'b1 : ~act_q[f];
                else if (fall && (md == CR_BM_MOMENT || (md == CR_BM_HYBRID && lng)))
                    act_q[f] <= 1'b0;
            end
        end
    end

    // Knob silence, flash acknowledge and level steps per encoder
    for (genvar k = 0; k < 8; k++) begin : g_knob
        logic          kp_q;
        logic [3:0]    fleft_q;
        logic [FW-1:0] fms_q;
        logic [5:0]    attn_q;
        logic          lmute_q;
        wire           tap = knob_press[k] & ~kp_q;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                kp_q       <= 1'b0;
                kmute_q[k] <= 1'b0;
                fleft_q    <= 4'h0;
                fms_q      <= '0;
                knob_purple[k] <= 1'b0;
                knob_blue[k]   <= 1'b1;
            end else begin
                kp_q <= knob_press[k];
                if (tap && knob_en_q[k]) kmute_q[k] <= ~kmute_q[k];
                if (tap && !knob_en_q[k]) begin
                    fleft_q <= 4'(2 * `CR_FLASHES);
                    fms_q   <= '0;
                end else if (fleft_q != 4'h0 && ms_tick_q) begin
                    fms_q   <= fms_q == FW'(FLASH_MS - 1) ? '0 : fms_q + 1'b1;
                    if (fms_q == FW'(FLASH_MS - 1)) fleft_q <= fleft_q - 4'h1;
                end
                knob_purple[k] <= kmute_q[k] | lmute_q | fleft_q[0];
                knob_blue[k]   <= ~(kmute_q[k] | lmute_q | fleft_q[0]);
            end
        end
        // Level: one dB a step, floor stop or full mute past the floor
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                attn_q  <= 6'h00;
                lmute_q <= 1'b0;
            end else if (enc_cw[k]) begin
                if (lmute_q) lmute_q <= 1'b0;
                else if (attn_q != 6'h00) attn_q <= attn_q - 6'h01;
            end else if (enc_ccw[k]) begin
                if (attn_q < floor_db) attn_q <= attn_q + 6'h01;
                else if (floor_mode == CR_FL_MUTE) lmute_q <= 1'b1;
                else attn_q <= floor_db;
            end
        end
        assign enc_attn[k*6 +: 6] = attn_q;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) enc_mute[k] <= 1'b0;
            else enc_mute[k] <= lmute_q | kmute_q[k];
        end
    end

    // Tone sources
    logic signed [15:0] tone_tally;
    logic signed [15:0] tone_mark;
    cr_tone #(.STEP(16'(`CR_STEP(`CR_TALLY_HZ)))) u_tally (
        .pclk    (pclk),
        .presetn (presetn),
        .en      (fs_tick_q),
        .tone    (tone_tally)
    );
    cr_tone #(.STEP(16'(`CR_STEP(`CR_MARK_HZ)))) u_mark (
        .pclk    (pclk),
        .presetn (presetn),
        .en      (fs_tick_q),
        .tone    (tone_mark)
    );

    // Audio selection and saturating mix
    wire signed [AW-1:0] t_tally = AW'(tone_tally) <<< (AW - 16);
    wire signed [AW-1:0] t_mark  = AW'(tone_mark) <<< (AW - 16);
    wire signed [AW-1:0] mic_sel = mic_net_sel ? mic_net : mic_analog;
    wire signed [AW:0]   mix     = {mic_sel[AW-1], mic_sel} + {t_mark[AW-1], t_mark};
    wire signed [AW-1:0] mix_sat = (mix[AW] == mix[AW-1]) ? mix[AW-1:0] :
                                   {mix[AW], {(AW-1){~mix[AW]}}};
    wire                 main_a  = act_q[0];
    wire signed [AW-1:0] aux_d   = aux_mode == CR_AUX_HOT_MIC ? mic_analog :
                                   aux_mode == CR_AUX_TALLY ? (main_a ? t_tally : '0) :
                                   aux_mode == CR_AUX_MARK ? (main_a ? mix_sat : '0) : '0;
    wire signed [AW-1:0] mic_o_d = (mic_always | main_a) ? mic_analog : '0;
    wire                 st_en   = (st_mode == CR_ST_MAIN && main_a) ||
                                   (st_mode == CR_ST_TB && |act_q[6:1]) ||
                                   (st_mode == CR_ST_BOTH && (main_a || |act_q[6:1]));

    // Audio at the sample rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_tx  <= '0;
            mic_out <= '0;
        end else if (fs_tick_q) begin
            aux_tx  <= aux_d;
            mic_out <= mic_o_d;
        end
    end

    // Routing, status and tally pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preamp_analog <= 1'b1;
            main_on       <= 1'b0;
            tb_on         <= 6'h00;
            st_left       <= 1'b0;
            st_right      <= 1'b0;
            tally_q       <= 1'b0;
            remote_o      <= 4'h0;
            remote_oe     <= 4'h0;
        end else begin
            preamp_analog <= ~mic_net_sel | (aux_mode == CR_AUX_HOT_MIC);
            main_on       <= main_a;
            tb_on         <= act_q[6:1];
            st_left       <= st_en & st_route[0];
            st_right      <= st_en & st_route[1];
            tally_q       <= tally_sel & main_a;
            remote_o      <= {2'b00, tally_sel & main_a, 1'b0};
            remote_oe     <= {2'b00, tally_sel, 1'b0};
        end
    end
endmodule

// *** tb/cr_far_model.sv ***
// Far side of the console: remote contacts with pull-ups and two mic sources.
// Assumes the bench sets closures and samples; remote 2 may drive its pin back.
module cr_far_model (
    // Bench controls
    input  wire logic [3:0]    close,
    input  wire logic [15:0]   a_smp,
    input  wire logic [15:0]   n_smp,
    // Device side
    input  wire logic [3:0]    remote_o,
    input  wire logic [3:0]    remote_oe,
    output logic      [3:0]    remote_i,
    output logic signed [15:0] mic_analog,
    output logic signed [15:0] mic_net
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pin level: device drive wins, else a closure pulls low, else pull-up
    assign remote_i = (remote_oe & remote_o) | (~remote_oe & ~close);
    // Sources hold each sample until the bench gives the next
    assign mic_analog = a_smp;
    assign mic_net    = n_smp;
endmodule

// *** tb/cr_console_asserts.sv ***
// Concurrent checks on the console control outputs.
// Assumes binding into cr_console; sees its ports only.
module cr_console_asserts (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Watched signals
    input  wire logic [3:0]  remote_o,
    input  wire logic [3:0]  remote_oe,
    input  wire logic        main_on,
    input  wire logic [5:0]  tb_on,
    input  wire logic        st_left,
    input  wire logic        st_right,
    input  wire logic [7:0]  enc_cw,
    input  wire logic [7:0]  enc_ccw,
    input  wire logic [47:0] enc_attn,
    input  wire logic [7:0]  enc_mute,
    input  wire logic [7:0]  knob_blue,
    input  wire logic [7:0]  knob_purple
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Flags a level deeper than the deepest floor
    logic over;
    always_comb begin
        over = 1'b0;
        for (int i = 0; i < 8; i++)
            over = over | (enc_attn[6*i +: 6] > 6'h28);
    end
    a_oe_fixed: assert property ((remote_oe & 4'hD) == 4'h0)
        else $error("remote pin other than 2 driven");
    a_tally_pin: assert property (remote_oe[1] |-> remote_o[1] == main_on)
        else $error("tally pin does not follow main");
    a_st_cause: assert property (st_left || st_right |-> main_on || tb_on != 6'h0)
        else $error("sidetone without main or talkback");
    a_light_excl: assert property ((knob_blue & knob_purple) == 8'h0)
        else $error("knob blue and purple together");
    a_mute_purple: assert property ((enc_mute & ~knob_purple) == 8'h0)
        else $error("muted knob not purple");
    a_floor_max: assert property (!over)
        else $error("level below deepest floor");
    a_ccw_step: assert property (enc_ccw[2] && !enc_cw[2] && !enc_mute[2] && enc_attn[17:12] < 6'h1E
        |=> enc_attn[17:12] == $past(enc_attn[17:12]) + 6'h1)
        else $error("ccw step not one dB");
    a_cw_unmute: assert property (enc_cw[2] && enc_mute[2] |-> ##2 !enc_mute[2])
        else $error("cw did not unmute");
endmodule
bind cr_console cr_console_asserts u_chk (.*);

// *** tb/console_routing_and_remote_control_tb.sv ***
// Self-checking bench for the console control block.
// Assumes shortened counts: 10 cycles a ms, sample strobe every 8 cycles.
module console_routing_and_remote_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cr_pkg::*;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, main_btn = 1'h0;
    logic        pready, pslverr, er, preamp_analog, main_on, st_left, st_right, pp;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h5C78F6CD;
    logic [5:0]  tb_btn = 6'h0, tb_on;
    logic [7:0]  knob_press = 8'h0, enc_cw = 8'h0, enc_ccw = 8'h0, enc_mute, knob_blue, knob_purple;
    logic [3:0]  close = 4'h0, remote_i, remote_o, remote_oe;
    logic [15:0] a_smp = 16'h0, n_smp = 16'h0;
    logic [47:0] enc_attn;
    logic signed [15:0] mic_analog, mic_net, aux_tx, mic_out;
    int          n_mismatch = 0, n_tests = 0, r, s, n;
    always #20 pclk = ~pclk;
    cr_console #(.MS_CYC(10), .FS_CYC(8), .DEB_MS(2), .HOLD_MS(4), .FLASH_MS(2)) dut (.*);
    cr_far_model far (.*);
    // Verdict and end of run
    task automatic summarize;
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Compare one result
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // One APB transfer, bounded wait for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            summarize();
        end
    endtask
    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    // Random mic samples from the shift register, then wait past a sample strobe
    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], ^(v & 32'h80200003)};
    endfunction
    task automatic smp;
        lfsr = lfsr_step(lfsr);
        a_smp <= {{4{lfsr[15]}}, lfsr[15:4]};
        n_smp <= {{4{lfsr[31]}}, lfsr[31:20]};
        cyc(12);
    endtask
    // Aux less base stays within the -20 dBFS peak and moves
    task automatic tone(input logic [15:0] base);
        int d;
        logic ok = 1'b1, seen = 1'b0;
        repeat (24) begin
            @(posedge pclk);
            d = int'(aux_tx) - int'($signed(base));
            ok = ok & (d <= 3277 && d >= -3277);
            seen = seen | (d != 0);
        end
        chk("tone", 32'h1, ok & seen);
    endtask
    task automatic pulse(input logic cw);
        enc_cw[2]  <= cw;
        enc_ccw[2] <= !cw;
        @(posedge pclk);
        enc_cw[2]  <= 1'b0;
        enc_ccw[2] <= 1'b0;
        @(posedge pclk);
    endtask
    initial begin
        cyc(20);
        presetn <= 1'b1;
        cyc(2);
        rchk("ctrl", 12'h000, 32'h300);
        rchk("knob", 12'h00C, 32'hFF);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped", 32'h1, er);
        chk("blue", 32'hFF, knob_blue);
        $display("test reset done");
        // Aux modes, mic source and mic output with main off and on
        for (int m = 0; m < 4; m++) begin
            for (int on = 0; on < 2; on++) begin
                apb(1'b1, 12'h000, 32'h300 | m | (on << 2) | ((m & 1) << 3));
                main_btn <= on[0];
                smp();
                chk("main", on, main_on);
                chk("preamp", m == 1 || on == 0, preamp_analog);
                chk("mic_out", ((m & 1) || on) ? a_smp : 16'h0, $unsigned(mic_out));
                if (m < 2 || on == 0)
                    chk("aux", m == 1 ? a_smp : 16'h0, $unsigned(aux_tx));
                else
                    tone(m == 3 ? n_smp : 16'h0);
            end
        end
        $display("test aux done");
        // Sidetone modes against main and talkback, routing varied
        for (int i = 0; i < 16; i++) begin
            r = i % 3 + 1;
            apb(1'b1, 12'h000, (r << 8) | ((i / 4) << 6));
            main_btn <= i[0];
            tb_btn   <= {5'h0, i[1]};
            cyc(4);
            s = (i / 4 == 1 && i[0]) || (i / 4 == 2 && i[1]) || (i / 4 == 3 && (i[0] || i[1]));
            chk("st_left", s && r[0], st_left);
            chk("st_right", s && r[1], st_right);
        end
        main_btn <= 1'b0;
        tb_btn   <= 6'h0;
        $display("test sidetone done");
        // Remote 1 main, remote 2 tally, remote 3 latching talkback 3
        apb(1'b1, 12'h008, 32'h40);
        apb(1'b1, 12'h004, 32'h481);
        rchk("remote", 12'h004, 32'h481);
        close[0] <= 1'b1;
        cyc(40);
        chk("main remote", 32'h1, main_on);
        chk("tally on", 32'h1, remote_i[1]);
        close <= 4'h4;
        cyc(10);
        close <= 4'h0;
        cyc(40);
        chk("main off", 32'h0, main_on);
        chk("tally off", 32'h0, remote_i[1]);
        chk("glitch", 32'h0, tb_on);
        close[2] <= 1'b1;
        cyc(40);
        close <= 4'h8;
        cyc(40);
        chk("latched", 32'h4, tb_on);
        close <= 4'h0;
        apb(1'b1, 12'h004, 32'h8);
        rchk("no tally 1", 12'h004, 32'h0);
        $display("test remote done");
        // Knob tap with silence on, then off
        knob_press[0] <= 1'b1;
        cyc(3);
        knob_press[0] <= 1'b0;
        cyc(3);
        chk("mute0", 32'h1, enc_mute[0]);
        chk("purple0", 32'h1, knob_purple[0]);
        apb(1'b1, 12'h00C, 32'hFD);
        knob_press[1] <= 1'b1;
        cyc(3);
        knob_press[1] <= 1'b0;
        n = 0;
        pp = 1'b0;
        repeat (260) begin
            @(posedge pclk);
            if (knob_purple[1] & ~pp)
                n++;
            pp = knob_purple[1];
        end
        chk("flashes", 32'd5, n);
        chk("mute1", 32'h0, enc_mute[1]);
        $display("test knob done");
        // Floors -30, -40 and full mute on encoder 3
        for (int f = 0; f < 3; f++) begin
            apb(1'b1, 12'h000, 32'h300 | (f << 4));
            repeat (45) pulse(1'b0);
            chk("attn", f == 0 ? 32'd30 : 32'd40, enc_attn[17:12]);
            chk("floor mute", f == 2, enc_mute[2]);
        end
        pulse(1'b1);
        pulse(1'b1);
        chk("cw", 32'd39, enc_attn[17:12]);
        $display("test floor done");
        summarize();
    end
endmodule
